// *** hw/sleep_ctrl_pkg.sv ***
package sleep_ctrl_pkg;

    // ------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_IDLE     = 3'h0;
    localparam logic [2:0] MODE_NOISE    = 3'h1;
    localparam logic [2:0] MODE_PDOWN    = 3'h2;
    localparam logic [2:0] MODE_PSAVE    = 3'h3;
    localparam logic [2:0] MODE_STANDBY  = 3'h6;
    localparam logic [2:0] MODE_XSTANDBY = 3'h7;

    // ------------------------------------------------------------
    // Peripheral clock stop bit positions
    // ------------------------------------------------------------
    localparam int PR_WIDTH   = 8;
    localparam int PR_CONV    = 0;
    localparam int PR_TIMER2  = 6;
    localparam int PR_TWOWIRE = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int        CLK_MHZ          = 40;
    localparam int        XTAL_WAKE_CYCLES = 6;
    localparam int        IRQ_HALT_CYCLES  = 4;
    localparam int        CNT_W            = 16;
    localparam logic [15:0] TIMEOUT_DEFAULT = 16'h0040;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_SLEEP  = 3'b001,
        ST_START  = 3'b011,
        ST_HALT   = 3'b010,
        ST_RESUME = 3'b110
    } state_type;

    typedef struct packed {
        logic ext_reset;
        logic wdt_reset;
        logic wdt_irq;
        logic bod_reset;
        logic twi_match;
        logic level_irq;
        logic pin_change;
        logic timer2_ovf;
        logic timer2_cmp;
        logic other_irq;
    } wake_type;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic conv;
        logic async;
        logic main_osc;
        logic timer_osc;
    } clocks_type;

endpackage : sleep_ctrl_pkg

// *** hw/sleep_mode_power_control.sv ***
module sleep_mode_power_control
    import sleep_ctrl_pkg::*;
#(
    parameter logic [CNT_W-1:0] TIMEOUT_CYCLES = TIMEOUT_DEFAULT
)(
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                ce_i,
    input  wire logic [2:0]          sleep_mode_select_i,
    input  wire logic                sleep_enable_bit_i,
    input  wire logic                sleep_instr_i,
    input  wire logic                xtal_option_i,
    input  wire logic                timer2_enabled_i,
    input  wire logic                timer2_async_i,
    input  wire logic [1:0]          timer2_interrupt_mask_i,
    input  wire logic                global_irq_enable_i,
    input  wire wake_type            wake_i,
    input  wire logic [PR_WIDTH-1:0] peripheral_clock_stop_register_i,
    input  wire logic                conv_enable_i,
    input  wire logic                comp_enable_i,
    input  wire logic                comp_uses_ref_i,
    input  wire logic                debug_enable_fuse_i,
    input  wire logic                wdt_enable_i,
    input  wire logic                bod_fuse_enable_i,
    output clocks_type               clocks_o,
    output logic [PR_WIDTH-1:0]      periph_clk_en_o,
    output logic                     conv_power_o,
    output logic                     conv_extended_o,
    output logic                     comp_power_o,
    output logic                     ref_power_o,
    output logic                     input_buf_en_o,
    output logic                     wake_pin_buf_en_o,
    output logic                     wdt_power_o,
    output logic                     bod_power_o,
    output logic                     sleeping_o,
    output logic                     irq_take_o,
    output logic                     reset_vector_o
);

    // ------------------------------------------------------------
    // Wake request capture
    // ------------------------------------------------------------
    state_type   state;
    logic [2:0]  mode;
    logic [CNT_W-1:0] count;
    logic        wake_any;
    logic        reset_wake;
    logic        t2_wake;
    logic        level_sync1;
    logic        level_sync2;
    logic        wake_sync1;
    logic        wake_sync2;
    logic        reset_sync1;
    logic        reset_sync2;
    logic        other_sync1;
    logic        other_sync2;
    logic        deep;
    logic        t2_mode;
    logic        conv_prev;

    assign deep    = (mode == MODE_PDOWN) || (mode == MODE_PSAVE)
                  || (mode == MODE_STANDBY) || (mode == MODE_XSTANDBY);
    assign t2_mode = (mode == MODE_PSAVE) || (mode == MODE_XSTANDBY);

    // Timer 2 events count only when their enable and the global enable are set
    assign t2_wake = global_irq_enable_i
                  && ((wake_i.timer2_ovf && timer2_interrupt_mask_i[0])
                   || (wake_i.timer2_cmp && timer2_interrupt_mask_i[1]));

    assign reset_wake = wake_i.ext_reset || wake_i.wdt_reset || wake_i.bod_reset;

    always_comb
    begin
        wake_any = reset_wake || wake_i.wdt_irq || wake_i.twi_match
                || wake_i.level_irq || wake_i.pin_change;
        if (t2_mode)
        begin
            wake_any = wake_any || t2_wake;
        end
        if (!deep)
        begin
            wake_any = wake_any || wake_i.other_irq || t2_wake;
        end
    end

    // Wake sources are asynchronous; two flops before the state machine
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wake_sync1  <= 1'b0;
            wake_sync2  <= 1'b0;
            reset_sync1 <= 1'b0;
            reset_sync2 <= 1'b0;
            other_sync1 <= 1'b0;
            other_sync2 <= 1'b0;
            level_sync1 <= 1'b0;
            level_sync2 <= 1'b0;
        end
        else if (ce_i)
        begin
            wake_sync1  <= wake_any;
            wake_sync2  <= wake_sync1;
            reset_sync1 <= reset_wake;
            reset_sync2 <= reset_sync1;
            level_sync1 <= wake_i.level_irq;
            level_sync2 <= level_sync1;
            // Sources besides the level request that keep an interrupt pending
            other_sync1 <= wake_i.pin_change || wake_i.twi_match
                        || wake_i.wdt_irq || t2_wake;
            other_sync2 <= other_sync1;
        end
    end

    // ------------------------------------------------------------
    // Sleep sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state          <= ST_RUN;
            mode           <= MODE_IDLE;
            count          <= '0;
            irq_take_o     <= 1'b0;
            reset_vector_o <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_take_o     <= 1'b0;
            reset_vector_o <= 1'b0;
            case (state)
                ST_RUN:
                begin
                    if (sleep_instr_i && sleep_enable_bit_i)
                    begin
                        mode  <= sleep_mode_select_i;
                        state <= ST_SLEEP;
                    end
                end
                ST_SLEEP:
                begin
                    if (wake_sync2)
                    begin
                        state <= ST_START;
                        if ((mode == MODE_STANDBY || mode == MODE_XSTANDBY) && xtal_option_i)
                        begin
                            count <= CNT_W'(XTAL_WAKE_CYCLES - 1);
                        end
                        else if (deep)
                        begin
                            count <= TIMEOUT_CYCLES - 1'b1;
                        end
                        else
                        begin
                            count <= '0;
                        end
                    end
                end
                ST_START:
                begin
                    if (count == '0)
                    begin
                        if (reset_sync2)
                        begin
                            reset_vector_o <= 1'b1;
                            state          <= ST_RUN;
                        end
                        else
                        begin
                            count <= CNT_W'(IRQ_HALT_CYCLES - 1);
                            state <= ST_HALT;
                        end
                    end
                    else
                    begin
                        count <= count - 1'b1;
                    end
                end
                ST_HALT:
                begin
                    if (count == '0)
                    begin
                        state <= ST_RESUME;
                    end
                    else
                    begin
                        count <= count - 1'b1;
                    end
                end
                default:
                begin
                    // Level request gone after start-up, outside idle and with no other source pending: wake, no interrupt
                    irq_take_o <= !(mode != MODE_IDLE && !level_sync2
                                    && !other_sync2);
                    state      <= ST_RUN;
                end
            endcase
        end
    end

    assign sleeping_o = (state == ST_SLEEP);

    // ------------------------------------------------------------
    // Clock and power gating
    // ------------------------------------------------------------
    always_comb
    begin
        clocks_o = '{default: 1'b1};
        if (sleeping_o)
        begin
            clocks_o.cpu   = 1'b0;
            clocks_o.flash = 1'b0;
            if (mode == MODE_NOISE)
            begin
                clocks_o.io        = 1'b0;
                clocks_o.async     = timer2_async_i;
                clocks_o.timer_osc = timer2_async_i;
            end
            else if (deep)
            begin
                clocks_o.io        = 1'b0;
                clocks_o.conv      = 1'b0;
                clocks_o.async     = t2_mode && timer2_enabled_i;
                clocks_o.timer_osc = t2_mode && timer2_async_i;
                clocks_o.main_osc  = (mode == MODE_STANDBY)
                                  || (t2_mode && !timer2_async_i)
                                  || (mode == MODE_XSTANDBY);
            end
            if (debug_enable_fuse_i)
            begin
                clocks_o.main_osc = 1'b1;
            end
        end
    end

    // Gated peripheral clocks keep their state frozen while off
    assign periph_clk_en_o = ~peripheral_clock_stop_register_i;

    assign conv_power_o      = conv_enable_i;
    assign comp_power_o      = comp_enable_i && !(sleeping_o && deep);
    assign wdt_power_o       = wdt_enable_i;
    assign bod_power_o       = bod_fuse_enable_i;
    assign ref_power_o       = bod_fuse_enable_i || conv_enable_i
                            || (comp_enable_i && comp_uses_ref_i);
    assign input_buf_en_o    = !(sleeping_o && !clocks_o.io && !clocks_o.conv);
    assign wake_pin_buf_en_o = 1'b1;

    // Converter restart after power-off needs an extended conversion
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            conv_prev       <= 1'b0;
            conv_extended_o <= 1'b1;
        end
        else if (ce_i)
        begin
            conv_prev <= conv_enable_i;
            if (conv_enable_i && !conv_prev)
            begin
                conv_extended_o <= 1'b1;
            end
            else if (conv_enable_i && clocks_o.conv)
            begin
                conv_extended_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_pdown_osc_off: assert property (sleeping_o && mode == MODE_PDOWN && !debug_enable_fuse_i
        |-> !clocks_o.main_osc && !clocks_o.io) else $error("osc running in power-down");
    a_deep_io_off: assert property (sleeping_o && deep |-> !clocks_o.io && !clocks_o.cpu)
        else $error("clock running in deep sleep");
    a_standby_osc: assert property (sleeping_o && mode == MODE_STANDBY |-> clocks_o.main_osc)
        else $error("standby osc stopped");
    a_halt_four: assert property (ce_i && state == ST_START && count == '0 && !reset_sync2
        ##1 ce_i[*4] |=> state == ST_RESUME) else $error("halt length wrong");
    a_wdt_kept: assert property (wdt_enable_i |-> wdt_power_o)
        else $error("watchdog dropped");
    a_comp_off: assert property (sleeping_o && deep |-> !comp_power_o)
        else $error("comparator on in deep sleep");
    a_ref_needed: assert property (conv_enable_i || bod_fuse_enable_i |-> ref_power_o)
        else $error("reference off while needed");
    a_debug_clock: assert property (debug_enable_fuse_i |-> clocks_o.main_osc)
        else $error("debug clock stopped");
    a_buf_off: assert property (sleeping_o && deep |-> !input_buf_en_o)
        else $error("input buffers on");
    a_sleep_entry: assert property (state == ST_RUN && ce_i && sleep_instr_i
        && sleep_enable_bit_i |=> state == ST_SLEEP) else $error("sleep not entered");
    a_psave_t2_run: assert property (sleeping_o && mode == MODE_PSAVE && timer2_enabled_i
        |-> clocks_o.async) else $error("timer 2 clock stopped in power-save");
    a_psave_tosc: assert property (sleeping_o && mode == MODE_PSAVE && !timer2_async_i
        |-> !clocks_o.timer_osc) else $error("timer osc running in power-save");
    a_xstandby_osc: assert property (sleeping_o && mode == MODE_XSTANDBY |-> clocks_o.main_osc)
        else $error("extended standby osc stopped");
    a_noise_clocks: assert property (sleeping_o && mode == MODE_NOISE
        |-> !clocks_o.io && clocks_o.conv) else $error("noise mode gating wrong");
    a_bod_kept: assert property (bod_fuse_enable_i |-> bod_power_o)
        else $error("brown-out detector dropped");
    a_xtal_count: assert property (ce_i && state == ST_SLEEP && wake_sync2 && xtal_option_i
        && (mode == MODE_STANDBY || mode == MODE_XSTANDBY)
        |=> count == CNT_W'(XTAL_WAKE_CYCLES - 1)) else $error("standby wake count wrong");
    a_conv_restart: assert property (ce_i && conv_enable_i && !conv_prev |=> conv_extended_o)
        else $error("extended conversion not flagged");
    a_irq_pulse: assert property (ce_i && irq_take_o |=> !irq_take_o)
        else $error("interrupt pulse too long");

    c_pdown_wake: cover property (sleeping_o && mode == MODE_PDOWN ##1 state == ST_START);
    c_reset_wake: cover property (reset_vector_o);
    c_irq_wake: cover property (irq_take_o);
    c_level_gone: cover property (state == ST_RESUME && ce_i && mode != MODE_IDLE && !level_sync2 && !other_sync2);
    c_standby_wake: cover property (sleeping_o && mode == MODE_STANDBY ##1 state == ST_START);

endmodule : sleep_mode_power_control

// *** verification/tb_top.sv ***
module tb_top
    import sleep_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] TMO = 16'h0010;
    logic                clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1;
    logic [2:0]          sleep_mode_select_i = 3'h0;
    logic                sleep_enable_bit_i = 1'b0, sleep_instr_i = 1'b0;
    logic                xtal_option_i = 1'b1, timer2_enabled_i = 1'b0, timer2_async_i = 1'b0;
    logic [1:0]          timer2_interrupt_mask_i = 2'h0;
    logic                global_irq_enable_i = 1'b0;
    wake_type            wake_i = '0;
    logic [PR_WIDTH-1:0] peripheral_clock_stop_register_i = 8'h00;
    logic                conv_enable_i = 1'b0, comp_enable_i = 1'b0, comp_uses_ref_i = 1'b0;
    logic                debug_enable_fuse_i = 1'b0, wdt_enable_i = 1'b1, bod_fuse_enable_i = 1'b1;
    clocks_type          clocks_o;
    logic [PR_WIDTH-1:0] periph_clk_en_o;
    logic                conv_power_o, conv_extended_o, comp_power_o, ref_power_o;
    logic                input_buf_en_o, wake_pin_buf_en_o, wdt_power_o, bod_power_o;
    logic                sleeping_o, irq_take_o, reset_vector_o;
    int                  num_errors = 0, total_checks = 0, cycles = 0, n;
    logic                irq, rst;
    wake_type            w_pc, w_t2;

    sleep_mode_power_control #(.TIMEOUT_CYCLES(TMO)) i_dut (.*);

    initial forever #12.5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step();
        @(posedge clk_i);
        #2;
    endtask : step

    task automatic enter(input logic [2:0] m);
        sleep_mode_select_i = m;
        sleep_enable_bit_i  = 1'b1;
        sleep_instr_i       = 1'b1;
        step();
        sleep_instr_i = 1'b0;
        step();
        check("sleeping", sleeping_o, 1'b1);
    endtask : enter

    task automatic wake_up(input wake_type w, input bit drop, input int lim);
        wake_i = w;
        n      = 0;
        irq    = 1'b0;
        rst    = 1'b0;
        while (!irq && !rst && n < lim)
        begin
            step();
            n++;
            if (drop && sleeping_o === 1'b0)
                wake_i = '0;
            irq = (irq_take_o === 1'b1);
            rst = (reset_vector_o === 1'b1);
        end
        wake_i = '0;
        step();
    endtask : wake_up

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_power_down();
        conv_enable_i   = 1'b1;
        comp_enable_i   = 1'b1;
        comp_uses_ref_i = 1'b1;
        enter(MODE_PDOWN);
        check("pd clocks", clocks_o, 7'h00);
        check("pd bufs", input_buf_en_o, 1'b0);
        check("pd wakebuf", wake_pin_buf_en_o, 1'b1);
        check("pd comp", comp_power_o, 1'b0);
        check("pd ref", ref_power_o, 1'b1);
        check("pd conv", conv_power_o, 1'b1);
        check("pd wdt bod", {wdt_power_o, bod_power_o}, 2'h3);
        timer2_interrupt_mask_i = 2'h1;
        global_irq_enable_i     = 1'b1;
        wake_up(w_t2, 1'b0, 40);
        check("pd t2 ignored", sleeping_o, 1'b1);
        timer2_interrupt_mask_i = 2'h0;
        global_irq_enable_i     = 1'b0;
        wake_up(w_pc, 1'b0, 300);
        check("pd irq", irq, 1'b1);
        check("pd delay", n >= int'(TMO) + IRQ_HALT_CYCLES, 1'b1);
        conv_enable_i   = 1'b0;
        comp_enable_i   = 1'b0;
        comp_uses_ref_i = 1'b0;
        $display("test power down done");
    endtask : test_power_down

    task automatic test_level_vanish();
        wake_type w;
        w           = '0;
        w.level_irq = 1'b1;
        enter(MODE_PDOWN);
        wake_up(w, 1'b1, 60);
        check("lv irq", irq, 1'b0);
        check("lv awake", sleeping_o, 1'b0);
        $display("test level vanish done");
    endtask : test_level_vanish

    task automatic test_power_save();
        wake_type w;
        timer2_enabled_i        = 1'b1;
        timer2_interrupt_mask_i = 2'h1;
        enter(MODE_PSAVE);
        check("ps tosc", clocks_o.timer_osc, 1'b0);
        check("ps cpu", clocks_o.cpu, 1'b0);
        wake_up(w_t2, 1'b0, 40);
        check("ps no gie", sleeping_o, 1'b1);
        global_irq_enable_i = 1'b1;
        wake_up(w_t2, 1'b0, 300);
        check("ps t2 wake", irq, 1'b1);
        timer2_async_i = 1'b1;
        enter(MODE_PSAVE);
        check("ps async", {clocks_o.main_osc, clocks_o.timer_osc}, 2'h1);
        w                       = '0;
        w.timer2_cmp            = 1'b1;
        timer2_interrupt_mask_i = 2'h2;
        wake_up(w, 1'b0, 300);
        check("ps cmp wake", irq, 1'b1);
        timer2_interrupt_mask_i = 2'h0;
        timer2_async_i      = 1'b0;
        timer2_enabled_i    = 1'b0;
        global_irq_enable_i = 1'b0;
        $display("test power save done");
    endtask : test_power_save

    task automatic test_standby();
        enter(MODE_STANDBY);
        check("sb osc", {clocks_o.cpu, clocks_o.io, clocks_o.main_osc}, 3'h1);
        wake_up(w_pc, 1'b0, 300);
        check("sb fast", n >= XTAL_WAKE_CYCLES + IRQ_HALT_CYCLES && n < int'(TMO), 1'b1);
        enter(MODE_XSTANDBY);
        check("xs osc", clocks_o.main_osc, 1'b1);
        wake_up(w_pc, 1'b0, 300);
        check("xs fast", n < int'(TMO), 1'b1);
        xtal_option_i = 1'b0;
        enter(MODE_STANDBY);
        wake_up(w_pc, 1'b0, 300);
        check("sb no xtal", n >= int'(TMO) + IRQ_HALT_CYCLES, 1'b1);
        xtal_option_i = 1'b1;
        $display("test standby done");
    endtask : test_standby

    task automatic test_light_modes();
        enter(MODE_IDLE);
        check("idle clk", {clocks_o.cpu, clocks_o.flash, clocks_o.io, clocks_o.conv}, 4'h3);
        wake_up(w_pc, 1'b0, 300);
        enter(MODE_NOISE);
        check("noise clk", {clocks_o.cpu, clocks_o.flash, clocks_o.io, clocks_o.conv}, 4'h1);
        wake_up(w_pc, 1'b0, 300);
        $display("test light modes done");
    endtask : test_light_modes

    task automatic test_misc();
        wake_type w;
        check("ext cleared", conv_extended_o, 1'b0);
        conv_enable_i = 1'b1;
        step();
        check("ext restart", conv_extended_o, 1'b1);
        step();
        check("ext done", conv_extended_o, 1'b0);
        conv_enable_i = 1'b0;
        peripheral_clock_stop_register_i = 8'hc1;
        step();
        check("pr stop", periph_clk_en_o, 8'h3e);
        peripheral_clock_stop_register_i = 8'h00;
        step();
        check("pr restart", periph_clk_en_o, 8'hff);
        bod_fuse_enable_i = 1'b0;
        step();
        check("ref off", ref_power_o, 1'b0);
        bod_fuse_enable_i   = 1'b1;
        enter(MODE_PDOWN);
        ce_i = 1'b0;
        wake_up(w_pc, 1'b0, 40);
        check("ce frozen", sleeping_o, 1'b1);
        ce_i = 1'b1;
        wake_up(w_pc, 1'b0, 300);
        check("ce resume", irq, 1'b1);
        debug_enable_fuse_i = 1'b1;
        enter(MODE_PDOWN);
        check("dbg osc", clocks_o.main_osc, 1'b1);
        w           = '0;
        w.ext_reset = 1'b1;
        wake_up(w, 1'b0, 300);
        check("rst vec", rst, 1'b1);
        debug_enable_fuse_i = 1'b0;
        $display("test misc done");
    endtask : test_misc

    initial
    begin
        w_pc            = '0;
        w_pc.pin_change = 1'b1;
        w_t2            = '0;
        w_t2.timer2_ovf = 1'b1;
        repeat (4) @(posedge clk_i);
        #2;
        check("ext flag", conv_extended_o, 1'b1);
        rstn_i = 1'b1;
        step();
        test_power_down();
        test_level_vanish();
        test_power_save();
        test_standby();
        test_light_modes();
        test_misc();
        test_done();
    end
endmodule : tb_top
